// file: logic/rmoc_regs.svh
`ifndef RMOC_REGS_SVH
`define RMOC_REGS_SVH

// ----------------------------------------------------------------
// Function pin configuration codes
// ----------------------------------------------------------------
`define RMOC_FPC_SYNTH_DIS 3'h0
`define RMOC_FPC_AUX_DIS 3'h1
`define RMOC_FPC_BOTH_DIS 3'h2
`define RMOC_FPC_MANUAL_EN 3'h3
`define RMOC_FPC_RSVD_A 3'h4
`define RMOC_FPC_AUTO_OVR 3'h5
`define RMOC_FPC_RSVD_B 3'h6
`define RMOC_FPC_FORCE_AUX 3'h7

// ----------------------------------------------------------------
// Auxiliary source codes
// ----------------------------------------------------------------
`define RMOC_AUX_RSVD 2'h0
`define RMOC_AUX_REF 2'h1
`define RMOC_AUX_SYNTH 2'h2
`define RMOC_AUX_LOCK 2'h3

// ----------------------------------------------------------------
// Input rate range codes and scale shifts
// ----------------------------------------------------------------
`define RMOC_RANGE_HIGH 2'h0
`define RMOC_RANGE_MID 2'h1
`define RMOC_RANGE_LOW 2'h2
`define RMOC_SHIFT_NONE 3'h0
`define RMOC_SHIFT_HALF 3'h1
`define RMOC_SHIFT_QUARTER 3'h2
`define RMOC_MANUAL_BASE 3'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RMOC_RATIO_RST 32'h0000_0000
`define RMOC_MODE_RST 2'h0

`endif

// file: logic/rmoc_pkg.sv
`default_nettype none

package rmoc_pkg;

    // One stored modal configuration set
    typedef struct packed {
        logic [1:0] manual_scale_select;
        logic [1:0] aux_source_select;
        logic auto_scale_enable;
    } rmoc_modal_t;

    // Global parameters, identical for every set
    typedef struct packed {
        logic unlock_pin_style;
        logic keep_output_when_unlocked;
        logic [2:0] function_pin_config;
        logic ratio_format_select;
        logic skip_tolerance_enable;
    } rmoc_global_t;

    // Reference clock disturbance reports from the loop
    typedef struct packed {
        logic discontinuity;
        logic skip_conditions_met;
        logic drift_exceeded;
        logic step_change;
    } rmoc_ref_event_t;

    typedef logic [3:0][31:0] rmoc_ratio_set_t;
    typedef rmoc_modal_t [3:0] rmoc_modal_set_t;

endpackage

`default_nettype wire

// file: logic/rmoc_ratio_mode_output_control.sv
// Behaviour
// - Effective ratio is user ratio times manual and automatic factors when enabled.
// - Two set pins pick one of four user ratios and modal sets.
// - Modal fields come from the selected set; globals apply to every set.
// - Synth pin copies synthesizer clock, low while unlocked unless keep set.
// - Config 000 or 010: function pin high floats the synth pin.
// - Aux pin muxes reference clock, synth clock or lock indicator.
// - Aux source codes: 00 reserved, 01 reference, 10 synth, 11 lock.
// - Unlock pin style picks driver type and polarity of indicator.
// - Aux synth clock phase need not match the synth pin.
// - Config 001 or 010: function pin can float the aux pin.
// - Configs 000-010: function pin low enables, high disables outputs.
// - Config 011: function pin alone enables manual scaling.
// - Config 101: function pin overrides stored automatic scale enable.
// - Config 111: function pin high forces aux source to synth clock.
// - Output gating never cuts synth-derived clock periods; a reference clock on the aux pin can be cut.
// - Glitch-free only among sources 00 and 10, not gating indicator.
// - Any set pin change drops lock temporarily.
// - Function pin change under configs 011-110 drops lock.
// - Reference discontinuity drops lock unless skip tolerance applies.
// - Drift beyond 30 percent or a step change drops lock.
// - User ratio format is 12.20 or 20.12 per format select.
// - Manual codes 00-11 scale by one half down to one sixteenth.
// - Automatic factor 1, 0.5 or 0.25 by input rate range.
`timescale 1ns/1ps
`include "rmoc_regs.svh"
`default_nettype none

module rmoc_ratio_mode_output_control (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] mode_select,
    input wire logic function_pin,
    input wire rmoc_pkg::rmoc_ratio_set_t user_ratio,
    input wire rmoc_pkg::rmoc_modal_set_t modal_sets,
    input wire rmoc_pkg::rmoc_global_t global_cfg,
    input wire logic [1:0] input_rate_range,
    input wire rmoc_pkg::rmoc_ref_event_t ref_events,
    input wire logic synth_clk,
    input wire logic ref_clk,
    input wire logic pll_locked,
    output logic [31:0] effective_ratio,
    output logic ratio_high_res,
    output logic lock_drop,
    output logic synth_pin_out,
    output logic synth_pin_oe_n,
    output logic aux_pin_out,
    output logic aux_pin_oe_n
);
    import rmoc_pkg::*;

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] auto_shift(input logic [1:0] range);
        case (range)
            `RMOC_RANGE_HIGH: auto_shift = `RMOC_SHIFT_NONE;
            `RMOC_RANGE_MID: auto_shift = `RMOC_SHIFT_HALF;
            `RMOC_RANGE_LOW: auto_shift = `RMOC_SHIFT_QUARTER;
            default: auto_shift = `RMOC_SHIFT_NONE;
        endcase
    endfunction

    function automatic logic is_cfg(input logic [2:0] cfg, input logic [2:0] code);
        is_cfg = (cfg == code);
    endfunction

    // ----------------------------------------------------------------
    // Set selection
    // ----------------------------------------------------------------
    rmoc_modal_t modal_sel;
    logic [31:0] ratio_sel;
    logic [2:0] fpc;
    logic manual_on;
    logic auto_on;
    logic [2:0] manual_amt;
    logic [2:0] auto_amt;
    logic [3:0] total_shift;
    logic synth_dis;
    logic aux_dis;
    logic [1:0] aux_src_eff;
    logic synth_gate_next;

    assign modal_sel = modal_sets[mode_select];
    assign ratio_sel = user_ratio[mode_select];
    assign fpc = global_cfg.function_pin_config;

    // ----------------------------------------------------------------
    // Effective ratio
    // ----------------------------------------------------------------
    // Reserved configs fall to the stored enables with no pin effect
    assign manual_on = is_cfg(fpc, `RMOC_FPC_MANUAL_EN) && function_pin;
    assign auto_on = is_cfg(fpc, `RMOC_FPC_AUTO_OVR) ? function_pin
                                                      : modal_sel.auto_scale_enable;
    assign manual_amt = manual_on ? ({1'b0, modal_sel.manual_scale_select} + `RMOC_MANUAL_BASE)
                                  : `RMOC_SHIFT_NONE;
    assign auto_amt = auto_on ? auto_shift(input_rate_range) : `RMOC_SHIFT_NONE;
    assign total_shift = {1'b0, manual_amt} + {1'b0, auto_amt};

    // Shifting keeps the binary point, so both formats scale alike
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            effective_ratio <= `RMOC_RATIO_RST;
            ratio_high_res <= 1'b0;
        end else begin
            effective_ratio <= ratio_sel >> total_shift;
            ratio_high_res <= global_cfg.ratio_format_select;
        end
    end

    // ----------------------------------------------------------------
    // Output disable and source selection
    // ----------------------------------------------------------------
    assign synth_dis = function_pin && (is_cfg(fpc, `RMOC_FPC_SYNTH_DIS) ||
                                        is_cfg(fpc, `RMOC_FPC_BOTH_DIS));
    assign aux_dis = function_pin && (is_cfg(fpc, `RMOC_FPC_AUX_DIS) ||
                                      is_cfg(fpc, `RMOC_FPC_BOTH_DIS));
    assign aux_src_eff = (is_cfg(fpc, `RMOC_FPC_FORCE_AUX) && function_pin) ? `RMOC_AUX_SYNTH
                                                                : modal_sel.aux_source_select;
    assign synth_gate_next = pll_locked || global_cfg.keep_output_when_unlocked;

    // ----------------------------------------------------------------
    // Gating state, updated only in the low phase of the synth clock
    // ----------------------------------------------------------------
    // Changing gates only while the clock is low means an output either
    // finishes its high half or never starts it: no runt periods
    logic synth_gate_reg;
    logic synth_dis_reg;
    logic aux_dis_reg;
    logic [1:0] aux_src_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            synth_gate_reg <= 1'b0;
            synth_dis_reg <= 1'b0;
            aux_dis_reg <= 1'b0;
            aux_src_reg <= `RMOC_AUX_RSVD;
        end else if (!synth_clk) begin
            synth_gate_reg <= synth_gate_next;
            synth_dis_reg <= synth_dis;
            aux_dis_reg <= aux_dis;
            aux_src_reg <= aux_src_eff;
        end
    end

    // ----------------------------------------------------------------
    // Synth pin
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            synth_pin_out <= 1'b0;
            synth_pin_oe_n <= 1'b1;
        end else begin
            synth_pin_out <= synth_clk && synth_gate_reg;
            synth_pin_oe_n <= synth_dis_reg;
        end
    end

    // ----------------------------------------------------------------
    // Aux pin mux
    // ----------------------------------------------------------------
    // Reference source is passed as sampled: switches to or from it may glitch
    logic aux_val;
    logic aux_float;

    always_comb begin
        aux_val = 1'b0;
        aux_float = aux_dis_reg;
        case (aux_src_reg)
            `RMOC_AUX_REF: aux_val = ref_clk;
            `RMOC_AUX_SYNTH: aux_val = synth_clk && synth_gate_reg;
            `RMOC_AUX_LOCK: begin
                if (global_cfg.unlock_pin_style) begin
                    aux_val = 1'b0;
                    aux_float = aux_dis_reg || pll_locked;
                end else begin
                    aux_val = !pll_locked;
                end
            end
            default: aux_val = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aux_pin_out <= 1'b0;
            aux_pin_oe_n <= 1'b1;
        end else begin
            aux_pin_out <= aux_val;
            aux_pin_oe_n <= aux_float;
        end
    end

    // ----------------------------------------------------------------
    // Lock-drop events
    // ----------------------------------------------------------------
    // Pins are captured after reset so no spurious drop is seen at release
    logic [1:0] mode_prev_reg;
    logic fpin_prev_reg;
    logic fpin_relock;
    logic ref_drop;

    assign fpin_relock = is_cfg(fpc, `RMOC_FPC_MANUAL_EN) || is_cfg(fpc, `RMOC_FPC_RSVD_A) ||
                         is_cfg(fpc, `RMOC_FPC_AUTO_OVR) || is_cfg(fpc, `RMOC_FPC_RSVD_B);
    assign ref_drop = (ref_events.discontinuity &&
                       !(global_cfg.skip_tolerance_enable && ref_events.skip_conditions_met)) ||
                      ref_events.drift_exceeded || ref_events.step_change;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_prev_reg <= `RMOC_MODE_RST;
            fpin_prev_reg <= 1'b0;
        end else begin
            mode_prev_reg <= mode_select;
            fpin_prev_reg <= function_pin;
        end
    end

    logic armed_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_drop <= 1'b0;
        end else begin
            lock_drop <= ref_drop ||
                         (armed_reg && (mode_select != mode_prev_reg)) ||
                         (armed_reg && fpin_relock && (function_pin != fpin_prev_reg));
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_mode_drop: assert property (@(posedge core_clk) disable iff (rst)
        armed_reg && (mode_select != mode_prev_reg) |=> lock_drop)
        else $error("set pin change did not drop lock");

    a_ref_drop: assert property (@(posedge core_clk) disable iff (rst)
        ref_events.discontinuity && !global_cfg.skip_tolerance_enable |=> lock_drop)
        else $error("reference discontinuity did not drop lock");

    a_unlock_low: assert property (@(posedge core_clk) disable iff (rst)
        !synth_clk && !pll_locked && !global_cfg.keep_output_when_unlocked
        |-> ##2 !synth_pin_out)
        else $error("synth pin toggled while unlocked");

    a_synth_float: assert property (@(posedge core_clk) disable iff (rst)
        !synth_clk && function_pin && fpc == `RMOC_FPC_SYNTH_DIS ##1 1'b1 |=> synth_pin_oe_n)
        else $error("synth pin not floated by function pin");

    a_aux_float: assert property (@(posedge core_clk) disable iff (rst)
        !synth_clk && function_pin && fpc == `RMOC_FPC_BOTH_DIS ##1 1'b1 |=> aux_pin_oe_n)
        else $error("aux pin not floated by function pin");

    a_manual_off: assert property (@(posedge core_clk) disable iff (rst)
        fpc == `RMOC_FPC_MANUAL_EN && !function_pin && !modal_sel.auto_scale_enable
        |=> effective_ratio == $past(ratio_sel))
        else $error("manual scale applied without function pin");

    a_auto_override: assert property (@(posedge core_clk) disable iff (rst)
        fpc == `RMOC_FPC_AUTO_OVR && function_pin && input_rate_range == `RMOC_RANGE_MID
        |=> effective_ratio == ($past(ratio_sel) >> 1))
        else $error("automatic override did not halve ratio");

    a_force_aux: assert property (@(posedge core_clk) disable iff (rst)
        !synth_clk && function_pin && fpc == `RMOC_FPC_FORCE_AUX |=> aux_src_reg == `RMOC_AUX_SYNTH)
        else $error("aux source not forced to synth clock");

    a_gate_low_phase: assert property (@(posedge core_clk) disable iff (rst)
        $changed(synth_gate_reg) || $changed(synth_dis_reg) |-> $past(!synth_clk))
        else $error("gate changed during high clock phase");

    a_open_drain: assert property (@(posedge core_clk) disable iff (rst)
        aux_src_reg == `RMOC_AUX_LOCK && global_cfg.unlock_pin_style |=> !aux_pin_out)
        else $error("open drain indicator drove high");

    a_fpin_drop: assert property (@(posedge core_clk) disable iff (rst)
        armed_reg && (fpc == `RMOC_FPC_MANUAL_EN || fpc == `RMOC_FPC_RSVD_A ||
        fpc == `RMOC_FPC_AUTO_OVR || fpc == `RMOC_FPC_RSVD_B) && $changed(function_pin)
        |=> lock_drop)
        else $error("function pin change did not drop lock");

    a_event_drop: assert property (@(posedge core_clk) disable iff (rst)
        ref_events.drift_exceeded || ref_events.step_change |=> lock_drop)
        else $error("reference frequency change did not drop lock");

    a_synth_enable: assert property (@(posedge core_clk) disable iff (rst)
        !synth_clk && !function_pin && fpc == `RMOC_FPC_BOTH_DIS ##1 1'b1 |=> !synth_pin_oe_n)
        else $error("synth pin not driven with function pin low");

    a_ratio_format: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> ratio_high_res == $past(global_cfg.ratio_format_select))
        else $error("ratio format flag does not follow the selection");

    a_manual_max: assert property (@(posedge core_clk) disable iff (rst)
        fpc == `RMOC_FPC_MANUAL_EN && function_pin && modal_sel.manual_scale_select == 2'h3 &&
        !modal_sel.auto_scale_enable |=> effective_ratio == ($past(ratio_sel) >> 4))
        else $error("manual scale code 11 did not divide by sixteen");

endmodule

`default_nettype wire

// file: dv/rmoc_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// System side: makes clocks, watches pins
// ----------------------------------------
module rmoc_sys_model (
    input wire logic core_clk,
    input wire logic run_en,
    input wire logic ref_lvl,
    input wire logic synth_pin_out,
    input wire logic synth_pin_oe_n,
    output logic synth_clk,
    output logic ref_clk,
    output logic runt_seen
);
    logic [1:0] div = 2'h0;
    logic [2:0] high_cnt = 3'h0;
    initial runt_seen = 1'b0;
    // Synth clock stops low outside bursts so gating loads settle
    assign synth_clk = div[1];
    assign ref_clk = ref_lvl;
    always @(posedge core_clk) begin
        div <= run_en ? div + 2'h1 : 2'h0;
        // A floated pin reads low downstream, so gating by enable is judged too
        if (synth_pin_out && !synth_pin_oe_n) begin
            high_cnt <= high_cnt + 3'h1;
        end else begin
            // A high phase is two cycles; anything shorter is a runt
            if (high_cnt != 3'h0 && high_cnt < 3'h2) runt_seen <= 1'b1;
            high_cnt <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: dv/rmoc_ratio_mode_output_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module rmoc_ratio_mode_output_control_test;
    import rmoc_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode_select = 2'h0;
    logic function_pin = 1'b0;
    rmoc_ratio_set_t user_ratio;
    rmoc_modal_set_t modal_sets;
    rmoc_global_t global_cfg;
    logic [1:0] input_rate_range = 2'h0;
    rmoc_ref_event_t ref_events;
    logic pll_locked = 1'b1;
    logic run_en = 1'b0;
    logic ref_lvl = 1'b0;
    logic synth_clk, ref_clk, runt_seen, ratio_high_res, lock_drop;
    logic synth_pin_out, synth_pin_oe_n, aux_pin_out, aux_pin_oe_n;
    logic [31:0] effective_ratio;
    logic [6:0] row;
    int n_fail = 0;
    int n_tests = 0;
    int hs, ha;
    always #12.5 core_clk = ~core_clk;
    rmoc_ratio_mode_output_control dut_u (.core_clk(core_clk), .rst(rst),
        .mode_select(mode_select), .function_pin(function_pin), .user_ratio(user_ratio),
        .modal_sets(modal_sets), .global_cfg(global_cfg), .input_rate_range(input_rate_range),
        .ref_events(ref_events), .synth_clk(synth_clk), .ref_clk(ref_clk),
        .pll_locked(pll_locked), .effective_ratio(effective_ratio),
        .ratio_high_res(ratio_high_res), .lock_drop(lock_drop), .synth_pin_out(synth_pin_out),
        .synth_pin_oe_n(synth_pin_oe_n), .aux_pin_out(aux_pin_out),
        .aux_pin_oe_n(aux_pin_oe_n));
    rmoc_sys_model sys_u (.core_clk(core_clk), .run_en(run_en), .ref_lvl(ref_lvl),
        .synth_pin_out(synth_pin_out), .synth_pin_oe_n(synth_pin_oe_n),
        .synth_clk(synth_clk), .ref_clk(ref_clk),
        .runt_seen(runt_seen));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Counts high cycles of both pins over four synth periods
    task automatic count_hi(output int s, output int a);
        s = 0;
        a = 0;
        repeat (16) begin
            @(negedge core_clk);
            if (synth_pin_out === 1'b1) s++;
            if (aux_pin_out === 1'b1) a++;
        end
    endtask
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        #100000;
        n_fail++;
        print_verdict();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        // Low bits zero so no shift below truncates
        user_ratio = {32'h1000_0000, 32'h0040_0000, 32'h0280_0000, 32'h0100_0000};
        modal_sets = '0;
        global_cfg = 7'b0_0_110_1_0;
        ref_events = '0;
        step(12);
        rst = 1'b0;
        step(2);
        for (int k = 1; k < 5; k++) begin
            mode_select = 2'(k);
            step(1);
            chk("lock_drop", 1, lock_drop);
            chk("eff_ratio", user_ratio[2'(k)], effective_ratio);
            step(1);
            chk("lock_drop", 0, lock_drop);
        end
        chk("high_res", 1, ratio_high_res);
        global_cfg.ratio_format_select = 1'b0;
        function_pin = 1'b1;
        step(1);
        chk("lock_drop", 1, lock_drop);
        chk("high_res", 0, ratio_high_res);
        chk("eff_ratio", user_ratio[0], effective_ratio);
        global_cfg.function_pin_config = 3'h3;
        for (int s = 0; s < 4; s++) begin
            modal_sets[0].manual_scale_select = 2'(s);
            step(1);
            chk("eff_manual", user_ratio[0] >> (s + 1), effective_ratio);
        end
        modal_sets[1].manual_scale_select = 2'h1;
        mode_select = 2'h1;
        step(1);
        chk("eff_set1", user_ratio[1] >> 2, effective_ratio);
        mode_select = 2'h0;
        function_pin = 1'b0;
        step(1);
        chk("eff_manual_off", user_ratio[0], effective_ratio);
        global_cfg.function_pin_config = 3'h6;
        modal_sets[0].auto_scale_enable = 1'b1;
        for (int r = 0; r < 4; r++) begin
            input_rate_range = 2'(r);
            step(1);
            chk("eff_auto", user_ratio[0] >> ((r == 3) ? 0 : r), effective_ratio);
        end
        global_cfg.function_pin_config = 3'h5;
        step(1);
        chk("eff_auto_ovr", user_ratio[0], effective_ratio);
        function_pin = 1'b1;
        input_rate_range = 2'h1;
        step(1);
        chk("eff_auto_ovr", user_ratio[0] >> 1, effective_ratio);
        step(1);
        // Events: step, drift, discontinuity, discontinuity with skip ok; the last pass sets skip enable
        for (int e = 0; e < 5; e++) begin
            row = {2'h0, 5'(e)};
            ref_events = (e == 0) ? 4'h1 : (e == 1) ? 4'h2 : (e == 2) ? 4'h8 : 4'hc;
            global_cfg.skip_tolerance_enable = (e == 4);
            step(1);
            chk("lock_drop_ref", (e == 4) ? 0 : 1, lock_drop);
            ref_events = '0;
            step(1);
        end
        modal_sets[0].aux_source_select = 2'h1;
        for (int c = 0; c < 3; c++) begin
            global_cfg.function_pin_config = 3'(c);
            step(4);
            chk("synth_oe_n", (c != 1), synth_pin_oe_n);
            chk("aux_oe_n", (c != 0), aux_pin_oe_n);
        end
        function_pin = 1'b0;
        step(4);
        chk("synth_oe_n", 0, synth_pin_oe_n);
        chk("aux_oe_n", 0, aux_pin_oe_n);
        global_cfg.function_pin_config = 3'h6;
        // Row: source, style, locked, ref level, aux out, aux oe_n
        for (int t = 0; t < 8; t++) begin
            row = (t == 0) ? 7'b00_0_1_1_0_0 : (t == 1) ? 7'b01_0_1_1_1_0 :
                (t == 2) ? 7'b01_0_1_0_0_0 : (t == 3) ? 7'b11_0_0_0_1_0 :
                (t == 4) ? 7'b11_0_1_0_0_0 : (t == 5) ? 7'b11_1_1_0_0_1 :
                (t == 6) ? 7'b11_1_0_0_0_0 : 7'b10_0_1_0_0_0;
            modal_sets[0].aux_source_select = row[6:5];
            global_cfg.unlock_pin_style = row[4];
            pll_locked = row[3];
            ref_lvl = row[2];
            step(4);
            chk("aux_out", row[1], aux_pin_out);
            chk("aux_oe_n", row[0], aux_pin_oe_n);
        end
        modal_sets[0].aux_source_select = 2'h1;
        global_cfg.function_pin_config = 3'h7;
        function_pin = 1'b1;
        run_en = 1'b1;
        step(8);
        count_hi(hs, ha);
        chk("synth_hi", 8, hs);
        chk("aux_forced_hi", 8, ha);
        function_pin = 1'b0;
        pll_locked = 1'b0;
        // Reference held high so the restored source differs from a gated synth clock
        ref_lvl = 1'b1;
        step(1);
        chk("lock_drop_fpc7", 0, lock_drop);
        step(7);
        count_hi(hs, ha);
        chk("synth_unlocked", 0, hs);
        chk("aux_restored", 16, ha);
        global_cfg.keep_output_when_unlocked = 1'b1;
        step(8);
        count_hi(hs, ha);
        chk("synth_keep", 8, hs);
        global_cfg.function_pin_config = 3'h0;
        for (int g = 0; g < 12; g++) begin
            function_pin = ~function_pin;
            pll_locked = g[1];
            global_cfg.keep_output_when_unlocked = g[2];
            step(3);
        end
        chk("runt", 0, runt_seen);
        print_verdict();
    end
endmodule
`default_nettype wire
